// *** inc/ttm_pkg.sv ***
// Purpose: shared constants and types of the three timer module
// Assumes: 32-bit APB data, each register one aligned word
// Notes: register byte address is index times four
package ttm_pkg;
    // ==========================================================
    // structure
    localparam int TMR_N = 3;
    localparam int CNT_W = 16;
    localparam int CORE = 0;
    localparam int AUX_LO = 1;
    localparam int AUX_HI = 2;
    localparam int RES_CYCLES = 4;
    localparam int DIV_W = 10;
    localparam int PRESC_W = 3;
    // ==========================================================
    // register indices
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_CNT = 6'h03;
    localparam logic [5:0] IDX_STAT = 6'h06;
    // ==========================================================
    // control fields
    localparam int F_MODE = 0;
    localparam int F_PRESC = 2;
    localparam int F_RUN = 5;
    localparam int F_DIRSW = 6;
    localparam int F_DIREXT = 7;
    localparam int F_GATELVL = 8;
    localparam int F_EDGE = 9;
    localparam int F_FN = 11;
    localparam int F_TOGSRC = 13;
    localparam int F_TOGOE = 14;
    // ==========================================================
    // status fields
    localparam int S_TOG = 0;
    localparam int S_OUT = 1;
    localparam int S_WRAP = 2;
    localparam int S_IN = 8;
    localparam int S_DIR = 11;
    // ==========================================================
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic TOG_RST = 1'b0;
    // ==========================================================
    // modes
    typedef enum logic [1:0] {
        MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_INCR
    } ttm_mode_t;
    typedef enum logic [1:0] {
        FN_OWN, FN_RELOAD, FN_CAPTURE, FN_SPARE
    } ttm_fn_t;
endpackage : ttm_pkg

// *** inc/ttm_cnt_if.sv ***
// Purpose: link between the timer top and one 16-bit counter
// Assumes: single clock domain
// Notes: wrap flags are one-cycle pulses
`timescale 1ns/10ps
interface ttm_cnt_if;
    logic step;
    logic up;
    logic load;
    logic [ttm_pkg::CNT_W-1:0] loadVal;
    logic [ttm_pkg::CNT_W-1:0] value;
    logic wrapUp;
    logic wrapDown;
    modport counter(input step, input up, input load, input loadVal,
        output value, output wrapUp, output wrapDown);
    modport ctrl(output step, output up, output load, output loadVal,
        input value, input wrapUp, input wrapDown);
endinterface : ttm_cnt_if

// *** hw/ttm_sync.sv ***
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clock
// Notes: first stage is read by the second stage only
`timescale 1ns/10ps
module ttm_sync #(
    parameter int N = 6
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [N-1:0] asyncIn,
    output logic [N-1:0] syncOut
);
    // ==========================================================
    // per-bit stages
    for (genvar b = 0; b < N; b++) begin : gBit
        logic meta_r;
        logic hold_r;
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                meta_r <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                meta_r <= asyncIn[b];
                hold_r <= meta_r;
            end
        end
        assign syncOut[b] = hold_r;
    end
endmodule : ttm_sync

// *** hw/ttm_count.sv ***
// Purpose: 16-bit up/down counter with load
// Assumes: load outranks step
// Notes: wrap pulses follow the edge that wrapped
`timescale 1ns/10ps
module ttm_count (
    input wire logic clock,
    input wire logic rstn,
    ttm_cnt_if.counter cnt
);
    logic [ttm_pkg::CNT_W-1:0] value_r;
    logic wrapUp_r;
    logic wrapDown_r;
    wire atMax = &value_r;
    wire atMin = ~|value_r;
    wire [ttm_pkg::CNT_W-1:0] inc = value_r + 16'h0001;
    wire [ttm_pkg::CNT_W-1:0] dec = value_r - 16'h0001;
    // ==========================================================
    // counting
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            value_r <= ttm_pkg::CNT_RST;
            wrapUp_r <= 1'b0;
            wrapDown_r <= 1'b0;
        end else begin
            if (cnt.load) begin
                value_r <= cnt.loadVal;
            end else if (cnt.step) begin
                value_r <= cnt.up ? inc : dec;
            end
            wrapUp_r <= ~cnt.load & cnt.step & cnt.up & atMax;
            wrapDown_r <= ~cnt.load & cnt.step & ~cnt.up & atMin;
        end
    end
    assign cnt.value = value_r;
    assign cnt.wrapUp = wrapUp_r;
    assign cnt.wrapDown = wrapDown_r;
endmodule : ttm_count

// *** hw/ttm_top.sv ***
// Purpose: three 16-bit timers, core plus two auxiliaries, on APB
// Assumes: pins asynchronous, 100 MHz clock
// Notes: pins are sampled every four cycles, edges found between samples
//
// What this block does
// - three 16-bit timers: one core timer, two auxiliary timers
// - each timer runs alone or chains to another through the latch
// - per-timer mode: timer, gated timer, event counter, incremental
// - timer mode steps on system clock through programmable prescaler
// - event counter mode steps on edges of its input pin
// - gated mode steps only while input pin holds the gate level
// - no timer steps faster than once per four clock cycles
// - direction from software bit, optionally flipped by direction pin
// - incremental mode decodes encoder A/B from input and direction pins
// - core toggle latch inverts on every core overflow and underflow
// - toggle latch state drives an output pin
// - toggle latch transitions can clock both auxiliary timers
// - auxiliary set as capture or reload register stops counting
// - capture: input pin edge copies core value into auxiliary
// - reload: core loaded from auxiliary on pin edge or latch edge
// - both auxiliaries reloading on opposite latch edges give PWM
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module ttm_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] timerInputPin,
    input wire logic [2:0] directionInputPin,
    output logic toggleLatchOutputPin
);
    localparam int DW = ttm_pkg::DIV_W;
    localparam int N = ttm_pkg::TMR_N;

    // ==========================================================
    // helpers
    function automatic logic prescHit(
        input logic [DW-1:0] div,
        input logic [ttm_pkg::PRESC_W-1:0] p
    );
        logic [DW-1:0] mask;
        mask = (DW'(ttm_pkg::RES_CYCLES) << p) - DW'(1);
        return (div & mask) == mask;
    endfunction : prescHit

    function automatic logic edgeHit(
        input logic rise,
        input logic fall,
        input logic [1:0] sel
    );
        return (sel[0] & rise) | (sel[1] & fall);
    endfunction : edgeHit

    function automatic logic [15:0] mergeLanes(
        input logic [15:0] old,
        input logic [15:0] wdat,
        input logic [1:0] strb
    );
        return {strb[1] ? wdat[15:8] : old[15:8],
                strb[0] ? wdat[7:0] : old[7:0]};
    endfunction : mergeLanes

    // ==========================================================
    // state
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic toggleOut_r;
    logic tog_r;
    logic [N-1:0] wrap_r;
    logic [DW-1:0] divCnt_r;
    logic sampNew_r;
    logic [N-1:0] inSamp_r;
    logic [N-1:0] inPrev_r;
    logic [N-1:0] dirSamp_r;
    logic [N-1:0] dirPrev_r;

    logic [N-1:0] stepW;
    logic [N-1:0] upW;
    logic [N-1:0] loadW;
    logic [N-1:0] reloadW;
    logic [N-1:0] captureW;
    logic [N-1:0] wrapHit;
    logic [N-1:0][15:0] loadValW;
    logic [N-1:0][15:0] cntVal;
    logic [N-1:0][15:0] ctrlW;
    logic [2*N-1:0] pinSync;

    ttm_cnt_if cntIf [N] ();

    // ==========================================================
    // pin synchronisers
    ttm_sync #(
        .N(2 * N)
    ) uSync (
        .clock(clock),
        .rstn(rstn),
        .asyncIn({directionInputPin, timerInputPin}),
        .syncOut(pinSync)
    );

    // ==========================================================
    // apb decode
    wire [5:0] regIdx = paddr[7:2];
    wire addrOk = (paddr[1:0] == 2'h0) && (regIdx <= ttm_pkg::IDX_STAT)
        && ((paddr >> 8) == '0);
    wire accessPh = psel & penable & ~pready_r;
    wire wrEn = psel & penable & pready_r & pwrite & ~pslverr_r;
    wire isCtrl = regIdx < ttm_pkg::IDX_CNT;
    wire isStat = regIdx == ttm_pkg::IDX_STAT;
    wire stWr = wrEn & isStat;
    wire [5:0] cntOff = regIdx - ttm_pkg::IDX_CNT;
    wire [N-1:0] wrapClr = (stWr & pstrb[0])
        ? pwdata[ttm_pkg::S_WRAP +: N] : '0;
    wire [15:0] statWord = {2'h0, dirSamp_r, inSamp_r, 3'h0, wrap_r,
        toggleOut_r, tog_r};
    wire [15:0] rdWord = isStat ? statWord
        : isCtrl ? ctrlW[regIdx[1:0]] : cntVal[cntOff[1:0]];

    // ==========================================================
    // sampling tick and prescaler base
    // one sample per four cycles caps every pin-driven step rate
    wire tick4 = prescHit(divCnt_r, '0);
    wire [N-1:0] inRise = inSamp_r & ~inPrev_r;
    wire [N-1:0] inFall = ~inSamp_r & inPrev_r;

    // ==========================================================
    // toggle latch transitions
    wire coreFlip = wrapHit[ttm_pkg::CORE];
    wire togRise = coreFlip & ~tog_r;
    wire togFall = coreFlip & tog_r;

    // ==========================================================
    // per-timer control
    for (genvar i = 0; i < N; i++) begin : gTmr
        localparam bit IS_AUX = (i != ttm_pkg::CORE);
        logic [15:0] ctrl_r;
        ttm_pkg::ttm_mode_t mode;
        ttm_pkg::ttm_fn_t fn;
        wire [1:0] esel = ctrl_r[ttm_pkg::F_EDGE +: 2];
        wire useTog = ctrl_r[ttm_pkg::F_TOGSRC];
        wire ctrlSel = regIdx == (ttm_pkg::IDX_CTRL + 6'(i));
        wire cntSel = regIdx == (ttm_pkg::IDX_CNT + 6'(i));
        wire swLoad = wrEn & cntSel;
        wire [15:0] swVal = mergeLanes(cntVal[i], pwdata[15:0],
            pstrb[1:0]);
        wire pinEv = sampNew_r & edgeHit(inRise[i], inFall[i], esel);
        wire togEv = edgeHit(togRise, togFall, esel);
        wire tick = prescHit(divCnt_r,
            ctrl_r[ttm_pkg::F_PRESC +: ttm_pkg::PRESC_W]);
        wire gateOpen = inSamp_r[i] == ctrl_r[ttm_pkg::F_GATELVL];
        wire quadChg = sampNew_r & ((inSamp_r[i] ^ inPrev_r[i])
            | (dirSamp_r[i] ^ dirPrev_r[i]));
        wire quadUp = inSamp_r[i] ^ dirPrev_r[i];
        wire cntEv = (IS_AUX && useTog) ? togEv : pinEv;
        wire extDown = ctrl_r[ttm_pkg::F_DIREXT] & dirSamp_r[i];
        wire ownFn = (fn == ttm_pkg::FN_OWN) || (fn == ttm_pkg::FN_SPARE);
        wire modeStep = (mode == ttm_pkg::MODE_TIMER) ? tick
            : (mode == ttm_pkg::MODE_GATED) ? (tick & gateOpen)
            : (mode == ttm_pkg::MODE_COUNTER) ? cntEv
            : quadChg;

        assign mode = ttm_pkg::ttm_mode_t'(ctrl_r[ttm_pkg::F_MODE +: 2]);
        assign fn = IS_AUX ? ttm_pkg::ttm_fn_t'(ctrl_r[ttm_pkg::F_FN +: 2])
            : ttm_pkg::FN_OWN;
        // each timer keeps its own settings
        assign stepW[i] = ctrl_r[ttm_pkg::F_RUN] & ownFn & modeStep;
        assign upW[i] = (mode == ttm_pkg::MODE_INCR)
            ? (quadUp ^ ctrl_r[ttm_pkg::F_DIRSW])
            : ~(ctrl_r[ttm_pkg::F_DIRSW] ^ extDown);
        assign reloadW[i] = (fn == ttm_pkg::FN_RELOAD)
            & (useTog ? togEv : pinEv);
        assign captureW[i] = (fn == ttm_pkg::FN_CAPTURE) & pinEv;
        assign ctrlW[i] = ctrl_r;

        if (IS_AUX) begin : gAux
            assign loadW[i] = swLoad | captureW[i];
            assign loadValW[i] = swLoad ? swVal
                : cntVal[ttm_pkg::CORE];
        end else begin : gCore
            // low auxiliary wins if both reload in one cycle
            assign loadW[i] = swLoad | reloadW[ttm_pkg::AUX_LO]
                | reloadW[ttm_pkg::AUX_HI];
            assign loadValW[i] = swLoad ? swVal
                : reloadW[ttm_pkg::AUX_LO] ? cntVal[ttm_pkg::AUX_LO]
                : cntVal[ttm_pkg::AUX_HI];
        end

        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                ctrl_r <= ttm_pkg::CTRL_RST;
            end else if (wrEn && ctrlSel) begin
                ctrl_r <= mergeLanes(ctrl_r, pwdata[15:0], pstrb[1:0]);
            end
        end

        assign cntIf[i].step = stepW[i];
        assign cntIf[i].up = upW[i];
        assign cntIf[i].load = loadW[i];
        assign cntIf[i].loadVal = loadValW[i];
        assign cntVal[i] = cntIf[i].value;
        assign wrapHit[i] = cntIf[i].wrapUp | cntIf[i].wrapDown;

        ttm_count uCnt (
            .clock(clock),
            .rstn(rstn),
            .cnt(cntIf[i])
        );
    end

    // ==========================================================
    // apb response, one wait state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= accessPh;
            pslverr_r <= accessPh & ~addrOk;
            if (accessPh) begin
                prdata_r <= (addrOk && !pwrite) ? {16'h0000, rdWord}
                    : 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // pin sampling
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            divCnt_r <= '0;
            sampNew_r <= 1'b0;
            inSamp_r <= '0;
            inPrev_r <= '0;
            dirSamp_r <= '0;
            dirPrev_r <= '0;
        end else begin
            divCnt_r <= divCnt_r + DW'(1);
            sampNew_r <= tick4;
            if (tick4) begin
                inPrev_r <= inSamp_r;
                inSamp_r <= pinSync[N-1:0];
                dirPrev_r <= dirSamp_r;
                dirSamp_r <= pinSync[2*N-1:N];
            end
        end
    end

    // ==========================================================
    // toggle latch, wrap flags, output pin
    // a hardware flip outranks a software write in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tog_r <= ttm_pkg::TOG_RST;
            toggleOut_r <= 1'b0;
            wrap_r <= '0;
        end else begin
            if (coreFlip) begin
                tog_r <= ~tog_r;
            end else if (stWr && pstrb[0]) begin
                tog_r <= pwdata[ttm_pkg::S_TOG];
            end
            toggleOut_r <= tog_r
                & ctrlW[ttm_pkg::CORE][ttm_pkg::F_TOGOE];
            wrap_r <= (wrap_r & ~wrapClr) | wrapHit;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign toggleLatchOutputPin = toggleOut_r;
endmodule : ttm_top

// *** verif/ttm_top_asserts.sv ***
// Purpose: port-level checks of the three timer module
// Assumes: one clock domain, async active-low reset
// Notes: bus checks only; timer effects are judged by the bench
`timescale 1ns/10ps
module ttm_top_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic toggleLatchOutputPin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // bus answer timing
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready longer than a cycle");
    property p_cause; pready |-> $past(psel) && $past(penable); endproperty
    a_cause: assert property (p_cause) else $error("pready without access");
    property p_wait;
        psel && penable && !pready && !$past(penable) |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state count off");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    // ==========================================================
    // decode and data
    property p_top; pready |-> prdata[31:16] == 16'h0000; endproperty
    a_top: assert property (p_top) else $error("upper read bits set");
    property p_align; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
    a_align: assert property (p_align) else $error("unaligned accepted");
    property p_range; pready && paddr > 8'h18 |-> pslverr; endproperty
    a_range: assert property (p_range) else $error("unmapped accepted");
    property p_ok;
        pready && paddr[1:0] == 2'b00 && paddr <= 8'h18 |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    // read data only moves on a captured access
    property p_hold; !(psel && penable) |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("prdata moved when idle");
    c_err: cover property (pready && pslverr);
    c_ok: cover property (pready && !pslverr);
    c_pin: cover property ($rose(toggleLatchOutputPin));
endmodule : ttm_top_asserts
bind ttm_top ttm_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.clock(clock),
    .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .toggleLatchOutputPin(toggleLatchOutputPin));

// *** verif/ttm_pins.sv ***
// Purpose: far-side pins: gate, count, direction and encoder lines
// Assumes: levels held well beyond the four-cycle sample period
// Notes: changes land by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module ttm_pins (
    input wire logic clock,
    output logic [2:0] inPin,
    output logic [2:0] dirPin
);
    logic [1:0] ph = 2'b00;
    initial begin
        inPin = 3'h0;
        dirPin = 3'h0;
    end
    // ==========================================================
    // edge trains for count and capture inputs
    task automatic pulse(input int i, input int n, input int hold);
        repeat (n) begin
            @(posedge clock);
            inPin[i] <= 1'b1;
            repeat (hold) @(posedge clock);
            inPin[i] <= 1'b0;
            repeat (hold - 1) @(posedge clock);
        end
    endtask : pulse
    task automatic level(input int i, input logic v);
        @(posedge clock);
        inPin[i] <= v;
    endtask : level
    task automatic dirLvl(input int i, input logic v);
        @(posedge clock);
        dirPin[i] <= v;
    endtask : dirLvl
    // one line changes per step, as a real encoder does
    task automatic quad(input int i, input int n, input logic fwd);
        repeat (n) begin
            ph = fwd ? ph + 2'd1 : ph - 2'd1;
            @(posedge clock);
            inPin[i] <= ph[0] ^ ph[1];
            dirPin[i] <= ph[1];
            repeat (12) @(posedge clock);
        end
    endtask : quad
endmodule : ttm_pins

// *** verif/ttm_top_tb.sv ***
// Purpose: self-checking bench of the three timer module
// Assumes: 100 MHz clock, APB master with bounded waits
// Notes: rate checks allow one step of prescaler phase
`timescale 1ns/10ps
module ttm_top_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] tin;
    logic [2:0] tdir;
    logic tOut;
    logic [31:0] rv;
    logic [31:0] a;
    logic re;
    int errors = 0;
    int samplesChecked = 0;
    int h;
    int l;
    always #5 clock = ~clock;
    ttm_top #(.ADDR_W(8)) DUT (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerInputPin(tin), .directionInputPin(tdir),
        .toggleLatchOutputPin(tOut));
    ttm_pins PINS (.clock(clock), .inPin(tin), .dirPin(tdir));
    // ==========================================================
    // bus and compare tasks
    task automatic xfer(input logic w, input logic [7:0] ad,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        xfer(1'b1, ad, {16'h0, d}, 4'h3);
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        xfer(1'b0, ad, 32'h0, 4'h0);
    endtask : rd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input logic v, output int n);
        n = 0;
        while (tOut !== v && n < 1000) begin
            @(posedge clock);
            n++;
        end
    endtask : wt
    task automatic completeRun;
        $display("checks %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : completeRun
    // ==========================================================
    // watchdog: tests need about 1200 cycles
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        completeRun();
    end
    // ==========================================================
    // tests
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4));
            chk(rv, 32'h0);
        end
        rd(8'h1c);
        chk(32'(re), 32'h1);
        chk(rv, 32'h0);
        $display("test reset and decode done");
        wr(8'h0c, 16'h1234);
        xfer(1'b1, 8'h0c, 32'h00ff, 4'h1);
        rd(8'h0c);
        chk(rv, 32'h12ff);
        wr(8'h0c, 16'hfffe);
        wr(8'h00, 16'h4020);
        repeat (30) @(posedge clock);
        rd(8'h18);
        chk(rv[4:0], 32'h7);
        chk(32'(tOut), 32'h1);
        wr(8'h0c, 16'h0001);
        wr(8'h00, 16'h4060);
        repeat (40) @(posedge clock);
        rd(8'h18);
        chk(rv[1:0], 32'h0);
        rd(8'h0c);
        chk(rv[15:8], 32'hff);
        $display("test wrap done");
        wr(8'h00, 16'h0028);
        // start far from a wrap so the difference below stays small
        wr(8'h0c, 16'h0000);
        rd(8'h0c);
        a = rv;
        repeat (160) @(posedge clock);
        rd(8'h0c);
        chk(32'(rv - a >= 10 && rv - a <= 11), 32'h1);
        PINS.dirLvl(0, 1'b1);
        wr(8'h00, 16'h00a0);
        wr(8'h0c, 16'h0100);
        repeat (40) @(posedge clock);
        rd(8'h0c);
        chk(32'(rv < 32'h100 && rv > 32'hf0), 32'h1);
        $display("test rate and direction done");
        wr(8'h04, 16'h0222);
        PINS.pulse(1, 5, 10);
        repeat (10) @(posedge clock);
        rd(8'h10);
        chk(rv, 32'h5);
        wr(8'h08, 16'h0121);
        repeat (40) @(posedge clock);
        rd(8'h14);
        chk(rv, 32'h0);
        PINS.level(2, 1'b1);
        repeat (80) @(posedge clock);
        PINS.level(2, 1'b0);
        repeat (10) @(posedge clock);
        rd(8'h14);
        chk(32'(rv >= 19 && rv <= 21), 32'h1);
        $display("test counter and gate done");
        PINS.dirLvl(0, 1'b0);
        wr(8'h00, 16'h0023);
        repeat (10) @(posedge clock);
        wr(8'h0c, 16'h0100);
        PINS.quad(0, 4, 1'b1);
        rd(8'h0c);
        chk(rv, 32'h104);
        PINS.quad(0, 4, 1'b0);
        rd(8'h0c);
        chk(rv, 32'h100);
        $display("test encoder done");
        wr(8'h00, 16'h0020);
        wr(8'h04, 16'h1200);
        PINS.pulse(1, 1, 10);
        repeat (10) @(posedge clock);
        rd(8'h10);
        a = rv;
        rd(8'h0c);
        chk(32'(a > 32'h100 && a <= rv), 32'h1);
        repeat (20) @(posedge clock);
        rd(8'h10);
        chk(rv, a);
        $display("test capture done");
        wr(8'h04, 16'h2a00);
        wr(8'h08, 16'h2c00);
        wr(8'h10, 16'hfff0);
        wr(8'h14, 16'hffe0);
        wr(8'h0c, 16'hfff0);
        wr(8'h00, 16'h4020);
        wt(1'b0, h);
        wt(1'b1, h);
        wt(1'b0, h);
        wt(1'b1, l);
        chk(32'(h >= 58 && h <= 70), 32'h1);
        chk(32'(l >= 122 && l <= 134), 32'h1);
        $display("test reload pwm done");
        wr(8'h04, 16'h0000);
        wr(8'h08, 16'h2622);
        wr(8'h0c, 16'h0000);
        wr(8'h14, 16'h0000);
        wr(8'h0c, 16'hfff8);
        repeat (40) @(posedge clock);
        wr(8'h0c, 16'hfff8);
        repeat (40) @(posedge clock);
        rd(8'h14);
        chk(rv, 32'h2);
        $display("test latch clock done");
        completeRun();
    end
endmodule : ttm_top_tb
